// [ext_irq_pkg.sv]
// Constants for the external interrupt front end.
//==============================================================
// Overview of operation
// - Trapped fetch gives reset or trap interrupt.
// - Trap interrupt taken even during non-maskable service.
// - Five external inputs, each with noise filter.
// - Interrupt zero pin is port after reset.
// - Interrupt zero falling edge only, gated by pin bit.
// - Inputs zero, five: reject under 2, pass 7.
// - Input one: noise-time bit picks 63 or 15.
// - Inputs two, three: reject under 7, pass 25.
// - Slow modes: reject under one, pass 3.5 slow ticks.
// - Edge-select bits 1..3: zero rising, one falling.
// - Edge latched within establish time plus six ticks.
// - Noise-time change effective within 26 core cycles.
// - Control register resets zero, bits 5,4,0 unused.
// - Control window 0000-003F, buffer window 0F80-0FFF.
// - Latch holds until accepted or cleared.
//==============================================================
`default_nettype none
package ext_irq_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          NUM_SRC       = 5;
    localparam logic [11:0] CTRL_WIN_LO   = 12'h000;
    localparam logic [11:0] CTRL_WIN_HI   = 12'h03f;
    localparam logic [11:0] BUF_WIN_LO    = 12'hf80;
    localparam logic [11:0] BUF_WIN_HI    = 12'hfff;
    localparam logic [11:0] OFS_CONTROL   = 12'h037;
    localparam logic [11:0] OFS_EN_LOW    = 12'h03a;
    localparam logic [11:0] OFS_EN_HIGH   = 12'h03b;
    localparam logic [11:0] OFS_LATCH_LOW = 12'h03c;
    localparam logic [11:0] OFS_LATCH_HI  = 12'h03d;
    localparam logic [7:0]  RST_CONTROL   = 8'h00;
    localparam logic [7:0]  RST_ENABLE    = 8'h00;
    localparam logic [7:0]  RST_LATCH     = 8'h00;
    // Control register fields.
    localparam int          BIT_NOISE_SEL = 7;
    localparam int          BIT_PIN_FUNC  = 6;
    localparam int          BIT_EDGE3     = 3;
    localparam int          BIT_EDGE2     = 2;
    localparam int          BIT_EDGE1     = 1;
    localparam logic [7:0]  CONTROL_MASK  = 8'hce;
    // Enable and latch bit positions (low byte 0..7, high 8..15).
    localparam int          BIT_MASTER_EN = 0;
    localparam int          FLAG_SRC0     = 4;
    localparam int          FLAG_SRC1     = 5;
    localparam int          FLAG_SRC2     = 7;
    localparam int          FLAG_SRC3     = 14;
    localparam int          FLAG_SRC5     = 15;
    // Reject times in high-frequency clock periods; the slow one in low-clock periods.
    localparam int          REJ_FAST_HF   = 2;
    localparam int          REJ_MID_HF    = 7;
    localparam int          REJ_LONG_HF   = 63;
    localparam int          REJ_SHORT_HF  = 15;
    localparam int          REJ_SLOW_LF   = 1;
    // The core clock is the high-frequency clock itself.
    localparam int          CLK_PER_HF    = 1;
    localparam logic [7:0]  CYC_FAST      = 8'(REJ_FAST_HF * CLK_PER_HF);
    localparam logic [7:0]  CYC_MID       = 8'(REJ_MID_HF * CLK_PER_HF);
    localparam logic [7:0]  CYC_LONG      = 8'(REJ_LONG_HF * CLK_PER_HF);
    localparam logic [7:0]  CYC_SHORT     = 8'(REJ_SHORT_HF * CLK_PER_HF);
    // One extra low-clock sample so a pulse under one period never passes.
    localparam logic [7:0]  TICKS_SLOW    = 8'(REJ_SLOW_LF + 1);
endpackage
`default_nettype wire

// [ext_irq_noise_reject.sv]
// External interrupt front end: pin filters, latches, enables, trap.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_noise_reject (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    input  wire logic [4:0]  ext_irq_pin,
    input  wire logic        low_freq_clock,
    input  wire logic        slow_mode,
    input  wire logic        irq3_source_select,
    input  wire logic [4:0]  irq_accept,
    input  wire logic        trap_fetch,
    input  wire logic        trap_mode_irq,
    input  wire logic        nmi_active,
    output logic      [4:0]  irq_request,
    output logic             addr_trap_irq,
    output logic             trap_abort,
    output logic             trap_reset
);
    // Channel order on ext_irq_pin: zero, one, two, three, five.

    //==========================================================
    // Pin and low-clock synchronisers
    //==========================================================
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic [5:0] sync3_ff;
    logic [5:0] agreed_ff;
    logic [5:0] nxt_agreed;
    logic       lf_prev_ff;
    logic       nxt_lf_prev;
    logic       lf_tick;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            nxt_agreed[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i]
                                                         : agreed_ff[i];
        end
        nxt_lf_prev = agreed_ff[5];
        lf_tick     = agreed_ff[5] & ~lf_prev_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff   <= 6'h1f;
            sync2_ff   <= 6'h1f;
            sync3_ff   <= 6'h1f;
            agreed_ff  <= 6'h1f;
            lf_prev_ff <= 1'b0;
        end else begin
            sync1_ff   <= {low_freq_clock, ext_irq_pin};
            sync2_ff   <= sync1_ff;
            sync3_ff   <= sync2_ff;
            agreed_ff  <= nxt_agreed;
            lf_prev_ff <= nxt_lf_prev;
        end
    end

    //==========================================================
    // Register file
    //==========================================================
    logic [7:0]  control_ff;
    logic [15:0] enable_ff;
    logic [15:0] latch_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_control;
    logic [15:0] nxt_enable;
    logic [15:0] nxt_latch;
    logic [7:0]  nxt_rdata;
    logic [15:0] latch_set;
    logic [15:0] latch_clr;
    logic [15:0] latch_owned;
    logic        in_window;

    function automatic logic [15:0] src_to_flag(input logic [4:0] src);
        logic [15:0] f;
        f = 16'h0000;
        f[ext_irq_pkg::FLAG_SRC0] = src[0];
        f[ext_irq_pkg::FLAG_SRC1] = src[1];
        f[ext_irq_pkg::FLAG_SRC2] = src[2];
        f[ext_irq_pkg::FLAG_SRC3] = src[3];
        f[ext_irq_pkg::FLAG_SRC5] = src[4];
        return f;
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    always_comb begin
        latch_owned = src_to_flag(5'h1f);
        // Only the control and buffer windows respond at all.
        in_window = (bus_addr <= ext_irq_pkg::CTRL_WIN_HI) |
                    (bus_addr >= ext_irq_pkg::BUF_WIN_LO);
        nxt_control = control_ff;
        nxt_enable  = enable_ff;
        nxt_rdata   = rdata_ff;
        latch_clr   = src_to_flag(irq_accept);
        if (bus_wr && in_window) begin
            if (hit(bus_addr, ext_irq_pkg::OFS_CONTROL)) begin
                nxt_control = bus_wdata & ext_irq_pkg::CONTROL_MASK;
            end
            if (hit(bus_addr, ext_irq_pkg::OFS_EN_LOW)) begin
                nxt_enable[7:0] = bus_wdata;
            end
            if (hit(bus_addr, ext_irq_pkg::OFS_EN_HIGH)) begin
                nxt_enable[15:8] = bus_wdata;
            end
            // Writing zero clears a latch; writing one leaves it alone.
            if (hit(bus_addr, ext_irq_pkg::OFS_LATCH_LOW)) begin
                latch_clr[7:0] = latch_clr[7:0] | ~bus_wdata;
            end
            if (hit(bus_addr, ext_irq_pkg::OFS_LATCH_HI)) begin
                latch_clr[15:8] = latch_clr[15:8] | ~bus_wdata;
            end
        end
        // A new edge in the clearing cycle is kept: set wins.
        nxt_latch = ((latch_ff & ~latch_clr) | latch_set) & latch_owned;
        if (bus_rd && in_window) begin
            case (bus_addr)
                ext_irq_pkg::OFS_CONTROL:   nxt_rdata = control_ff;
                ext_irq_pkg::OFS_EN_LOW:    nxt_rdata = enable_ff[7:0];
                ext_irq_pkg::OFS_EN_HIGH:   nxt_rdata = enable_ff[15:8];
                ext_irq_pkg::OFS_LATCH_LOW: nxt_rdata = latch_ff[7:0];
                ext_irq_pkg::OFS_LATCH_HI:  nxt_rdata = latch_ff[15:8];
                default:                    nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_ff <= ext_irq_pkg::RST_CONTROL;
            enable_ff  <= {2{ext_irq_pkg::RST_ENABLE}};
            latch_ff   <= {2{ext_irq_pkg::RST_LATCH}};
            rdata_ff   <= 8'h00;
        end else begin
            control_ff <= nxt_control;
            enable_ff  <= nxt_enable;
            latch_ff   <= nxt_latch;
            rdata_ff   <= nxt_rdata;
        end
    end

    //==========================================================
    // Noise filters and edge detection
    //==========================================================
    logic [4:0] filt_ff;
    logic [4:0] nxt_filt;
    logic [7:0] cnt_ff   [5];
    logic [7:0] nxt_cnt  [5];
    logic [7:0] need     [5];
    logic [4:0] want_fall;
    logic [4:0] edge_hit;
    logic       sample;

    // Threshold picks up a noise-time change on the next cycle.
    function automatic logic [7:0] reject_count(input int ch,
                                                input logic slow,
                                                input logic short_sel);
        logic [7:0] n;
        n = ext_irq_pkg::CYC_FAST;
        if (ch == 1) begin
            n = short_sel ? ext_irq_pkg::CYC_SHORT
                          : ext_irq_pkg::CYC_LONG;
        end
        if (ch == 2 || ch == 3) begin
            n = ext_irq_pkg::CYC_MID;
        end
        if (slow) begin
            n = ext_irq_pkg::TICKS_SLOW;
        end
        return n;
    endfunction

    always_comb begin
        // In the slow modes the filters advance on rising low-clock edges only.
        sample    = slow_mode ? lf_tick : 1'b1;
        want_fall = {1'b1,
                     control_ff[ext_irq_pkg::BIT_EDGE3],
                     control_ff[ext_irq_pkg::BIT_EDGE2],
                     control_ff[ext_irq_pkg::BIT_EDGE1],
                     1'b1};
    end

    generate
        for (genvar g = 0; g < ext_irq_pkg::NUM_SRC; g++) begin : g_filt
            always_comb begin
                need[g]     = reject_count(g, slow_mode,
                                  control_ff[ext_irq_pkg::BIT_NOISE_SEL]);
                nxt_cnt[g]  = cnt_ff[g];
                nxt_filt[g] = filt_ff[g];
                if (agreed_ff[g] == filt_ff[g]) begin
                    nxt_cnt[g] = 8'h00;
                end else if (sample) begin
                    if (cnt_ff[g] + 8'h01 >= need[g]) begin
                        nxt_filt[g] = agreed_ff[g];
                        nxt_cnt[g]  = 8'h00;
                    end else begin
                        nxt_cnt[g] = cnt_ff[g] + 8'h01;
                    end
                end
                edge_hit[g] = (nxt_filt[g] != filt_ff[g]) &&
                              (nxt_filt[g] == ~want_fall[g]);
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cnt_ff[g] <= 8'h00;
                end else begin
                    cnt_ff[g] <= nxt_cnt[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_ff <= 5'h1f;
        end else begin
            filt_ff <= nxt_filt;
        end
    end

    //==========================================================
    // Latch set, request gating and address trap
    //==========================================================
    logic [4:0]  src_edge;
    logic [4:0]  flag_en;
    logic [4:0]  irq_req_ff;
    logic [4:0]  nxt_irq_req;
    logic        trap_irq_ff;
    logic        trap_abort_ff;
    logic        trap_reset_ff;
    logic        nxt_trap_irq;
    logic        nxt_trap_abort;
    logic        nxt_trap_reset;

    always_comb begin
        src_edge    = edge_hit;
        // Port mode on the shared pin blocks its latch entirely.
        src_edge[0] = edge_hit[0] &
                      control_ff[ext_irq_pkg::BIT_PIN_FUNC];
        latch_set   = src_to_flag(src_edge);
        flag_en     = {enable_ff[ext_irq_pkg::FLAG_SRC5],
                       enable_ff[ext_irq_pkg::FLAG_SRC3] & ~irq3_source_select,
                       enable_ff[ext_irq_pkg::FLAG_SRC2],
                       enable_ff[ext_irq_pkg::FLAG_SRC1],
                       enable_ff[ext_irq_pkg::FLAG_SRC0]};
        nxt_irq_req = {latch_ff[ext_irq_pkg::FLAG_SRC5],
                       latch_ff[ext_irq_pkg::FLAG_SRC3],
                       latch_ff[ext_irq_pkg::FLAG_SRC2],
                       latch_ff[ext_irq_pkg::FLAG_SRC1],
                       latch_ff[ext_irq_pkg::FLAG_SRC0]} & flag_en &
                      {5{enable_ff[ext_irq_pkg::BIT_MASTER_EN]}};
        nxt_trap_reset = trap_fetch & ~trap_mode_irq;
        nxt_trap_irq   = trap_fetch & trap_mode_irq;
        // Trap is not masked by a running non-maskable service.
        nxt_trap_abort = trap_fetch & trap_mode_irq & nmi_active;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_req_ff    <= 5'h00;
            trap_irq_ff   <= 1'b0;
            trap_abort_ff <= 1'b0;
            trap_reset_ff <= 1'b0;
        end else begin
            irq_req_ff    <= nxt_irq_req;
            trap_irq_ff   <= nxt_trap_irq;
            trap_abort_ff <= nxt_trap_abort;
            trap_reset_ff <= nxt_trap_reset;
        end
    end

    assign bus_rdata     = rdata_ff;
    assign irq_request   = irq_req_ff;
    assign addr_trap_irq = trap_irq_ff;
    assign trap_abort    = trap_abort_ff;
    assign trap_reset    = trap_reset_ff;

endmodule // ext_irq_noise_reject
`default_nettype wire

// [ext_irq_noise_reject_asserts.sv]
// Checker for the trap outputs, request gating and register reads.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_noise_reject_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        irq3_source_select,
    input wire logic [4:0]  irq_accept,
    input wire logic        trap_fetch,
    input wire logic        trap_mode_irq,
    input wire logic        nmi_active,
    input wire logic [4:0]  irq_request,
    input wire logic        addr_trap_irq,
    input wire logic        trap_abort,
    input wire logic        trap_reset
);
    //==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence trap_irq_fetch;
        trap_fetch && trap_mode_irq;
    endsequence
    chk_trap_irq_out: assert property (
        trap_irq_fetch |=> addr_trap_irq && !trap_reset)
        else $error("trap interrupt missing");
    chk_trap_reset_out: assert property (
        trap_fetch && !trap_mode_irq |=> trap_reset && !addr_trap_irq)
        else $error("trap reset missing");
    chk_trap_abort_nmi: assert property (
        trap_irq_fetch ##0 nmi_active |=> trap_abort)
        else $error("trap did not abandon nmi service");
    chk_master_off: assert property (
        bus_wr && bus_addr == 12'h03a && !bus_wdata[0]
        |-> ##2 irq_request == 5'h00) else $error("request without master");
    chk_src3_stolen: assert property (
        irq3_source_select [*2] |-> !irq_request[3])
        else $error("source three not blocked");
    chk_accept_clears: assert property (
        irq_accept != 5'h00 |-> ##2 (irq_request & $past(irq_accept, 2))
        == 5'h00) else $error("accepted request still up");
    chk_latch_holds: assert property (
        irq_request[4] && !bus_wr && !$past(bus_wr) && !irq_accept[4]
        && !$past(irq_accept[4]) |=> irq_request[4])
        else $error("request dropped by itself");
    chk_unused_bits: assert property (
        bus_rd && bus_addr == 12'h037 |=> (bus_rdata & 8'h31) == 8'h00)
        else $error("unused control bits read nonzero");
endmodule // ext_irq_noise_reject_asserts
bind ext_irq_noise_reject ext_irq_noise_reject_asserts chk_u (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .irq3_source_select(irq3_source_select), .irq_accept(irq_accept),
    .trap_fetch(trap_fetch), .trap_mode_irq(trap_mode_irq),
    .nmi_active(nmi_active), .irq_request(irq_request),
    .addr_trap_irq(addr_trap_irq), .trap_abort(trap_abort),
    .trap_reset(trap_reset));
`default_nettype wire

// [ext_irq_pin_source.sv]
// Outside signal source that drives low pulses onto the interrupt pins.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_pin_source (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] idx,
    input  wire logic [8:0] width,
    output var logic  [4:0] pins
);
    //==========================================================
    // Pulse generator
    // Pins idle high, so one pulse gives a falling and a rising edge.
    initial pins = 5'h1f;
    always @(posedge clk) begin
        if (go) begin
            #1 pins[idx] = 1'b0;
            repeat (width) @(posedge clk);
            #1 pins[idx] = 1'b1;
        end
    end
endmodule // ext_irq_pin_source
`default_nettype wire

// [ext_irq_noise_reject_tb.sv]
// Self-checking bench for the external interrupt front end.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_noise_reject_tb;
    logic        clk, rst, bus_wr, bus_rd, low_freq_clock, slow_mode;
    logic        irq3_source_select, trap_fetch, trap_mode_irq, nmi_active;
    logic        addr_trap_irq, trap_abort, trap_reset, go, lng, m;
    logic [11:0] bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, d, ctl;
    logic [4:0]  pins, irq_accept, irq_request, q5;
    logic [2:0]  t3;
    logic [15:0] lat, e;
    int          errors, checks_done, k, s, g, r, p, w;
    int          seed = 10353;
    int          flag_pos [5] = '{4, 5, 7, 14, 15};
    //==========================================================
    // Design, pin source and clocks
    ext_irq_noise_reject dut_u (.clk(clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .ext_irq_pin(pins),
        .low_freq_clock(low_freq_clock), .slow_mode(slow_mode),
        .irq3_source_select(irq3_source_select), .irq_accept(irq_accept),
        .trap_fetch(trap_fetch), .trap_mode_irq(trap_mode_irq),
        .nmi_active(nmi_active), .irq_request(irq_request),
        .addr_trap_irq(addr_trap_irq), .trap_abort(trap_abort),
        .trap_reset(trap_reset));
    ext_irq_pin_source src_u (.clk(clk), .go(go), .idx(3'(s)),
        .width(9'(w)), .pins(pins));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // The slow oscillator runs free at one sixteenth of the core rate.
    initial begin
        low_freq_clock = 1'b0;
        forever #32 low_freq_clock = ~low_freq_clock;
    end
    //==========================================================
    // Tasks
    task automatic check(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Filter limits in core cycles; one slow tick is sixteen core cycles.
    function automatic int reject_len(input logic slow, input int ch,
                                      input logic short_sel);
        if (slow) return 16;
        if (ch == 0 || ch == 4) return 2;
        if (ch == 1) return short_sel ? 15 : 63;
        return 7;
    endfunction
    function automatic int pass_len(input logic slow, input int ch,
                                    input logic short_sel);
        if (slow) return 56;
        if (ch == 0 || ch == 4) return 7;
        if (ch == 1) return short_sel ? 49 : 193;
        return 25;
    endfunction
    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [7:0] v, output logic [7:0] q);
        @(posedge clk);
        #1 bus_addr = a;
        bus_wdata = v;
        bus_wr = wr;
        bus_rd = !wr;
        @(posedge clk);
        #1 bus_wr = 1'b0;
        bus_rd = 1'b0;
        q = bus_rdata;
    endtask
    task automatic final_report;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        final_report();
    end
    //==========================================================
    // Main sequence
    initial begin
        {bus_wr, bus_rd, slow_mode, irq3_source_select, go, s, w} = '0;
        {trap_fetch, trap_mode_irq, nmi_active, irq_accept} = '0;
        bus_addr = 12'h000;
        bus_wdata = 8'h00;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        foreach (flag_pos[i]) begin
            acc(1'b0, 12'h037 + 12'(i == 0 ? 0 : i + 2), 8'h00, d);
            check("reset value", {8'h00, d}, 16'h0000);
        end
        acc(1'b1, 12'h037, 8'hff, d);
        acc(1'b0, 12'h037, 8'h00, d);
        check("control", {8'h00, d}, 16'h00ce);
        acc(1'b1, 12'h437, 8'h00, d);
        acc(1'b0, 12'h040, 8'h00, d);
        check("outside read", {8'h00, d}, 16'h00ce);
        acc(1'b0, 12'h037, 8'h00, d);
        check("outside write", {8'h00, d}, 16'h00ce);
        acc(1'b0, 12'hf80, 8'h00, d);
        check("buffer window", {8'h00, d}, 16'h0000);
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            #1 {nmi_active, trap_mode_irq} = 2'(k);
            trap_fetch = 1'b1;
            @(posedge clk);
            #1 trap_fetch = 1'b0;
            t3 = {k[0], k[0] & k[1], !k[0]};
            q5 = {2'h0, addr_trap_irq, trap_abort, trap_reset};
            check("trap", {11'h0, q5}, {13'h0, t3});
        end
        for (k = 0; k < 30; k++) begin
            g = k / 5;
            s = k % 5;
            lng = (g == 5) ? k[0] : !g[0];
            ctl = 8'($random(seed) & 14) | {k[1], g[1], 6'h00};
            m = 1'($random(seed));
            acc(1'b1, 12'h03a, 8'h00, d);
            acc(1'b1, 12'h03b, 8'h00, d);
            slow_mode = (g == 5);
            irq3_source_select = 1'($random(seed));
            acc(1'b1, 12'h037, ctl, d);
            acc(1'b1, 12'h03c, 8'h00, d);
            acc(1'b1, 12'h03d, 8'h00, d);
            acc(1'b1, 12'h03a, 8'hb0 | 8'(m), d);
            acc(1'b1, 12'h03b, 8'hc0, d);
            r = reject_len(slow_mode, s, ctl[7]);
            p = pass_len(slow_mode, s, ctl[7]);
            w = lng ? p + ($random(seed) & 7)
                    : 1 + ($random(seed) & 255) % (r - 1);
            @(posedge clk);
            #1 go = 1'b1;
            @(posedge clk);
            #1 go = 1'b0;
            repeat (w + 120) @(posedge clk);
            acc(1'b0, 12'h03c, 8'h00, lat[7:0]);
            acc(1'b0, 12'h03d, 8'h00, lat[15:8]);
            e = (lng && !(s == 0 && !ctl[6])) ? 16'h1 << flag_pos[s] : 16'h0;
            check("latch", lat, e);
            q5 = 5'((e != 0) && m && !(s == 3 && irq3_source_select)) << s;
            check("request", {11'h0, irq_request}, {11'h0, q5});
            @(posedge clk);
            #1 irq_accept = 5'h01 << s;
            @(posedge clk);
            #1 irq_accept = 5'h00;
            repeat (3) @(posedge clk);
            check("accepted", {11'h0, irq_request}, 16'h0000);
        end
        final_report();
    end
endmodule // ext_irq_noise_reject_tb
`default_nettype wire
